//--- scm_serial_ctrl.sv
// serial controller top: ahb-lite registers, i2c command/status, spi status flags
`default_nettype none
`include "scm_regs.svh"
// ****************************************************************
// Contract
// - spi rx valid flag is high exactly while the rx fifo holds a byte
// - a byte arriving at a full rx fifo sets the overrun flag
// - reading the serial data register clears the overrun flag
// - send-byte command transmits one byte, then clears itself
// - receive-byte command clocks in one byte, then clears itself
// - after a received byte drive ack if ack select is one, else nack
// - start or stop completion sets condition-done; next activity clears it
// - byte received sets byte-received flag; next activity clears it
// - byte sent sets byte-sent flag; next activity clears it
// - slave nack on a sent byte sets nack flag; next activity clears it
// ****************************************************************
module scm_serial_ctrl import scm_pkg::*; #(
  parameter int FIFO_DEPTH = `SCM_FIFO_DEPTH,
  parameter int QTR_CYCLES = `SCM_I2C_QTR_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  input wire logic mode_i2c,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] spi_rx_data,
  input wire logic spi_rx_valid,
  output logic spi_rx_ready,
  output logic [7:0] spi_tx_data,
  output logic spi_tx_valid,
  input wire logic spi_tx_ready,
  input wire logic spi_tx_busy
);
  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic take, rd_take, data_rd, wr_cmd, wr_ack, wr_data, wr_imask, wr_istat;
  logic dp_wr_r, dp_wr_nxt;
  logic [17:0] dp_addr_r, dp_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [3:0] cmd_r, cmd_nxt, i2c_stat_r, i2c_stat_nxt, spi_stat;
  logic ack_r, ack_nxt, ovf_r, ovf_nxt, ovf_event;
  logic [4:0] int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt, ev;
  logic [7:0] txb_r, txb_nxt, rx_head, eng_rx;
  logic rx_in_ready, rx_out_valid, tx_in_ready, tx_push;
  logic eng_begin, eng_done, eng_nack;
  scm_op_type eng_op;
  assign take = hsel && htrans[1] && hready;
  assign rd_take = take && !hwrite;
  // side effects of reads act in the address phase so the data phase needs no wait
  assign data_rd = rd_take && (haddr[17:0] == {`SCM_IDX_DATA, 2'b00});
  assign wr_cmd = dp_wr_r && (dp_addr_r == {`SCM_IDX_I2C_CMD, 2'b00});
  assign wr_ack = dp_wr_r && (dp_addr_r == {`SCM_IDX_I2C_ACK, 2'b00});
  assign wr_data = dp_wr_r && (dp_addr_r == {`SCM_IDX_DATA, 2'b00});
  assign wr_imask = dp_wr_r && (dp_addr_r == {`SCM_IDX_INT_MASK, 2'b00});
  assign wr_istat = dp_wr_r && (dp_addr_r == {`SCM_IDX_INT_STAT, 2'b00});
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign spi_stat[`SCM_SPI_TXIDLE_BIT] = !spi_tx_valid && !spi_tx_busy;
  assign spi_stat[`SCM_SPI_TXFREE_BIT] = tx_in_ready;
  assign spi_stat[`SCM_SPI_RXVAL_BIT] = rx_out_valid;
  assign spi_stat[`SCM_SPI_RXOVF_BIT] = ovf_r;
  always_comb begin
    dp_wr_nxt = take && hwrite;
    dp_addr_nxt = take ? haddr[17:0] : dp_addr_r;
    hrdata_nxt = hrdata_r;
    if (rd_take) begin
      if (haddr[17:0] == {`SCM_IDX_SPI_STAT, 2'b00}) begin
        hrdata_nxt = {28'h0000000, spi_stat};
      end else if (haddr[17:0] == {`SCM_IDX_I2C_STAT, 2'b00}) begin
        hrdata_nxt = {28'h0000000, i2c_stat_r};
      end else if (haddr[17:0] == {`SCM_IDX_I2C_CMD, 2'b00}) begin
        hrdata_nxt = {28'h0000000, cmd_r};
      end else if (haddr[17:0] == {`SCM_IDX_I2C_ACK, 2'b00}) begin
        hrdata_nxt = {31'h00000000, ack_r};
      end else if (haddr[17:0] == {`SCM_IDX_DATA, 2'b00}) begin
        hrdata_nxt = {24'h000000, mode_i2c ? eng_rx : rx_head};
      end else if (haddr[17:0] == {`SCM_IDX_INT_STAT, 2'b00}) begin
        hrdata_nxt = {27'h0000000, int_stat_r};
      end else if (haddr[17:0] == {`SCM_IDX_INT_MASK, 2'b00}) begin
        hrdata_nxt = {27'h0000000, int_mask_r};
      end else begin
        hrdata_nxt = 32'h00000000;
      end
    end
  end
  // ****************************************************************
  // i2c command, acknowledge and status registers
  // ****************************************************************
  always_comb begin
    cmd_nxt = cmd_r;
    if (eng_done) begin
      cmd_nxt[eng_op] = 1'b0;
    end
    // a software write landing with a completion wins
    if (wr_cmd) begin
      cmd_nxt = hwdata[3:0];
    end
    ack_nxt = wr_ack ? hwdata[`SCM_ACK_SEL_BIT] : ack_r;
    txb_nxt = (wr_data && mode_i2c) ? hwdata[7:0] : txb_r;
    i2c_stat_nxt = eng_begin ? 4'h0 : i2c_stat_r;
    if (eng_done) begin
      if (eng_op == SCM_OP_START || eng_op == SCM_OP_STOP) begin
        i2c_stat_nxt[`SCM_ST_COND_BIT] = 1'b1;
      end else if (eng_op == SCM_OP_RECV) begin
        i2c_stat_nxt[`SCM_ST_RXFIN_BIT] = 1'b1;
      end else begin
        i2c_stat_nxt[`SCM_ST_TXFIN_BIT] = 1'b1;
        i2c_stat_nxt[`SCM_ST_NACK_BIT] = eng_nack;
      end
    end
  end
  // ****************************************************************
  // spi overrun and interrupts
  // ****************************************************************
  assign ovf_event = spi_rx_valid && !rx_in_ready;
  assign ev[`SCM_INT_OVF_BIT] = ovf_event;
  assign ev[`SCM_INT_COND_BIT] = eng_done && (eng_op == SCM_OP_START || eng_op == SCM_OP_STOP);
  assign ev[`SCM_INT_RXFIN_BIT] = eng_done && (eng_op == SCM_OP_RECV);
  assign ev[`SCM_INT_TXFIN_BIT] = eng_done && (eng_op == SCM_OP_SEND);
  assign ev[`SCM_INT_NACK_BIT] = eng_done && (eng_op == SCM_OP_SEND) && eng_nack;
  assign irq = |(int_stat_r & int_mask_r);
  assign tx_push = wr_data && !mode_i2c;
  always_comb begin
    // a new overrun in the cycle of the data read keeps the flag set
    ovf_nxt = ovf_event || (ovf_r && !data_rd);
    int_stat_nxt = (int_stat_r & ~(wr_istat ? hwdata[4:0] : 5'h00)) | ev;
    int_mask_nxt = wr_imask ? hwdata[4:0] : int_mask_r;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 18'h00000;
      hrdata_r <= 32'h00000000;
      cmd_r <= 4'(`SCM_RESET_16);
      ack_r <= 1'b0;
      txb_r <= 8'h00;
      i2c_stat_r <= 4'h0;
      ovf_r <= 1'b0;
      int_stat_r <= 5'h00;
      int_mask_r <= 5'h00;
    end else begin
      dp_wr_r <= dp_wr_nxt;
      dp_addr_r <= dp_addr_nxt;
      hrdata_r <= hrdata_nxt;
      cmd_r <= cmd_nxt;
      ack_r <= ack_nxt;
      txb_r <= txb_nxt;
      i2c_stat_r <= i2c_stat_nxt;
      ovf_r <= ovf_nxt;
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
    end
  end
  // ****************************************************************
  // fifos and i2c engine
  // ****************************************************************
  scm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(spi_rx_valid),
    .in_data(spi_rx_data),
    .in_ready(rx_in_ready),
    .out_valid(rx_out_valid),
    .out_data(rx_head),
    .out_ready(data_rd && !mode_i2c)
  );
  assign spi_rx_ready = rx_in_ready;
  // a data write to a full tx fifo is dropped; software checks tx space first
  scm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(tx_push),
    .in_data(hwdata[7:0]),
    .in_ready(tx_in_ready),
    .out_valid(spi_tx_valid),
    .out_data(spi_tx_data),
    .out_ready(spi_tx_ready)
  );
  scm_i2c_engine #(.QTR_CYCLES(QTR_CYCLES)) u_i2c (
    .clk(clk),
    .rst_n(rst_n),
    .cmd_start(cmd_r[`SCM_CMD_START_BIT]),
    .cmd_stop(cmd_r[`SCM_CMD_STOP_BIT]),
    .cmd_send(cmd_r[`SCM_CMD_SEND_BIT]),
    .cmd_recv(cmd_r[`SCM_CMD_RECV_BIT]),
    .ack_select(ack_r),
    .tx_byte(txb_r),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .begin_pulse(eng_begin),
    .done_pulse(eng_done),
    .done_op(eng_op),
    .nack_seen(eng_nack),
    .rx_byte(eng_rx)
  );
  // ****************************************************************
  // independent fifo levels, read only by the checks
  // ****************************************************************
  // counted apart from the fifo pointers so that a pointer slip shows in the checks
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  logic [LW-1:0] rx_lvl_r, rx_lvl_nxt, tx_lvl_r, tx_lvl_nxt;
  always_comb begin
    rx_lvl_nxt = rx_lvl_r + LW'(spi_rx_valid && (rx_lvl_r != LW'(FIFO_DEPTH)))
      - LW'(data_rd && !mode_i2c && (rx_lvl_r != '0));
    tx_lvl_nxt = tx_lvl_r + LW'(tx_push && (tx_lvl_r != LW'(FIFO_DEPTH)))
      - LW'(spi_tx_ready && (tx_lvl_r != '0));
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_lvl_r <= '0;
      tx_lvl_r <= '0;
    end else begin
      rx_lvl_r <= rx_lvl_nxt;
      tx_lvl_r <= tx_lvl_nxt;
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  chk_rxval_push: assert property (@(posedge clk) disable iff (!rst_n)
    (spi_rx_valid && !rx_out_valid) |=> spi_stat[`SCM_SPI_RXVAL_BIT])
    else $error("rx valid flag not raised after byte into empty fifo");
  chk_rxval_pop: assert property (@(posedge clk) disable iff (!rst_n)
    (data_rd && !mode_i2c && !spi_rx_valid && rx_lvl_r == LW'(1))
    |=> !spi_stat[`SCM_SPI_RXVAL_BIT])
    else $error("rx valid flag stays after last byte read");
  chk_ovf_set: assert property (@(posedge clk) disable iff (!rst_n)
    (spi_rx_valid && !rx_in_ready) |=> ovf_r ##1 (ovf_r || $past(data_rd)))
    else $error("overrun flag not set on byte into full fifo");
  chk_ovf_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (data_rd && !ovf_event) |=> !spi_stat[`SCM_SPI_RXOVF_BIT])
    else $error("overrun flag not cleared by data read");
  chk_send_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && eng_op == SCM_OP_SEND && !wr_cmd) |=> !cmd_r[`SCM_CMD_SEND_BIT])
    else $error("send command bit not cleared at completion");
  chk_recv_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && eng_op == SCM_OP_RECV && !wr_cmd) |=> !cmd_r[`SCM_CMD_RECV_BIT])
    else $error("receive command bit not cleared at completion");
  chk_cond_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && (eng_op == SCM_OP_START || eng_op == SCM_OP_STOP))
    |=> i2c_stat_r[`SCM_ST_COND_BIT] && int_stat_r[`SCM_INT_COND_BIT])
    else $error("condition done flag not set");
  chk_begin_clears: assert property (@(posedge clk) disable iff (!rst_n)
    eng_begin |=> (i2c_stat_r == 4'h0))
    else $error("i2c status flags not cleared at new activity");
  chk_tx_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && eng_op == SCM_OP_SEND) |=> i2c_stat_r[`SCM_ST_TXFIN_BIT])
    else $error("byte sent flag not set");
  chk_nack_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && eng_op == SCM_OP_SEND) |=> (i2c_stat_r[`SCM_ST_NACK_BIT] == $past(eng_nack)))
    else $error("nack flag does not match slave answer");
  chk_tx_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (spi_tx_busy || spi_tx_valid) |-> !spi_stat[`SCM_SPI_TXIDLE_BIT])
    else $error("tx idle flagged while busy or fifo not empty");
  chk_start_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && eng_op == SCM_OP_START && !wr_cmd) |=> !cmd_r[`SCM_CMD_START_BIT] ##1 !eng_begin)
    else $error("start command bit not cleared or engine restarted");
  chk_rxval_level: assert property (@(posedge clk) disable iff (!rst_n)
    spi_stat[`SCM_SPI_RXVAL_BIT] == (rx_lvl_r != '0))
    else $error("rx valid flag disagrees with rx fifo level");
  chk_ovf_full: assert property (@(posedge clk) disable iff (!rst_n)
    (spi_rx_valid && rx_lvl_r == LW'(FIFO_DEPTH)) |=> spi_stat[`SCM_SPI_RXOVF_BIT])
    else $error("overrun flag not set on byte into full rx fifo");
  chk_txfree_level: assert property (@(posedge clk) disable iff (!rst_n)
    spi_stat[`SCM_SPI_TXFREE_BIT] == (tx_lvl_r != LW'(FIFO_DEPTH)))
    else $error("tx space flag disagrees with tx fifo level");
  chk_txidle_level: assert property (@(posedge clk) disable iff (!rst_n)
    spi_stat[`SCM_SPI_TXIDLE_BIT] == (tx_lvl_r == '0 && !spi_tx_busy))
    else $error("tx idle flag disagrees with tx fifo level");
  chk_rx_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && eng_op == SCM_OP_RECV)
    |=> i2c_stat_r[`SCM_ST_RXFIN_BIT])
    else $error("byte received flag not set");
  chk_nack_recv: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && eng_op == SCM_OP_RECV) |=> !i2c_stat_r[`SCM_ST_NACK_BIT])
    else $error("nack flag set after a received byte");
  chk_stop_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (eng_done && eng_op == SCM_OP_STOP && !wr_cmd) |=> !cmd_r[`SCM_CMD_STOP_BIT])
    else $error("stop command bit not cleared at completion");
endmodule : scm_serial_ctrl
`default_nettype wire

//--- scm_regs.svh
// register indices, field positions, reset values and timing constants of the serial controller
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH
// register indices; byte address is four times the index
`define SCM_IDX_SPI_STAT 16'h4420
`define SCM_IDX_I2C_STAT 16'h4422
`define SCM_IDX_I2C_CMD 16'h4426
`define SCM_IDX_I2C_ACK 16'h4428
`define SCM_IDX_DATA 16'h441e
`define SCM_IDX_INT_STAT 16'h4440
`define SCM_IDX_INT_MASK 16'h4442
// spi status fields
`define SCM_SPI_TXIDLE_BIT 3
`define SCM_SPI_TXFREE_BIT 2
`define SCM_SPI_RXVAL_BIT 1
`define SCM_SPI_RXOVF_BIT 0
// i2c command fields
`define SCM_CMD_STOP_BIT 3
`define SCM_CMD_START_BIT 2
`define SCM_CMD_SEND_BIT 1
`define SCM_CMD_RECV_BIT 0
`define SCM_ACK_SEL_BIT 0
// i2c status fields
`define SCM_ST_COND_BIT 3
`define SCM_ST_RXFIN_BIT 2
`define SCM_ST_TXFIN_BIT 1
`define SCM_ST_NACK_BIT 0
// interrupt status and mask fields
`define SCM_INT_OVF_BIT 4
`define SCM_INT_COND_BIT 3
`define SCM_INT_RXFIN_BIT 2
`define SCM_INT_TXFIN_BIT 1
`define SCM_INT_NACK_BIT 0
`define SCM_RESET_16 16'h0000
// timing
`define SCM_CLK_PERIOD_NS 25
`define SCM_I2C_QTR_NS 2500
`define SCM_I2C_QTR_CYCLES (`SCM_I2C_QTR_NS / `SCM_CLK_PERIOD_NS)
`define SCM_FIFO_DEPTH 4
`endif

//--- scm_pkg.sv
// types shared by the serial controller modules
`default_nettype none
package scm_pkg;
  typedef enum logic [3:0] {
    SCM_ENG_IDLE = 4'h1,
    SCM_ENG_START = 4'h2,
    SCM_ENG_STOP = 4'h4,
    SCM_ENG_XFER = 4'h8
  } scm_eng_state_type;
  // values equal the command bit each operation clears
  typedef enum logic [1:0] {
    SCM_OP_RECV = 2'h0,
    SCM_OP_SEND = 2'h1,
    SCM_OP_START = 2'h2,
    SCM_OP_STOP = 2'h3
  } scm_op_type;
endpackage : scm_pkg
`default_nettype wire

//--- scm_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`default_nettype none
`include "scm_regs.svh"
module scm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SCM_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("scm_fifo depth must be a power of two of at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    mem_r <= mem_nxt;
  end
endmodule : scm_fifo
`default_nettype wire

//--- scm_i2c_engine.sv
// i2c master bit engine: start, stop, byte send and byte receive
`default_nettype none
`include "scm_regs.svh"
module scm_i2c_engine import scm_pkg::*; #(
  parameter int QTR_CYCLES = `SCM_I2C_QTR_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_send,
  input wire logic cmd_recv,
  input wire logic ack_select,
  input wire logic [7:0] tx_byte,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic begin_pulse,
  output logic done_pulse,
  output scm_op_type done_op,
  output logic nack_seen,
  output logic [7:0] rx_byte
);
  generate
    if (QTR_CYCLES < 1 || QTR_CYCLES > 65535) begin : g_bad_qtr
      $error("scm_i2c_engine quarter period out of range");
    end
  endgenerate
  scm_eng_state_type st_r, st_nxt;
  scm_op_type op_r, op_nxt;
  logic [15:0] qc_r, qc_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
  logic scl_rel_r, scl_rel_nxt, sda_rel_r, sda_rel_nxt;
  logic done_r, done_nxt, beg_r, beg_nxt, nack_r, nack_nxt;
  logic tick;
  assign tick = (qc_r == 16'(QTR_CYCLES - 1));
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = !scl_rel_r;
  assign sda_oe = !sda_rel_r;
  assign begin_pulse = beg_r;
  assign done_pulse = done_r;
  assign done_op = op_r;
  assign nack_seen = nack_r;
  assign rx_byte = rx_r;
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    scl_rel_nxt = scl_rel_r;
    sda_rel_nxt = sda_rel_r;
    nack_nxt = nack_r;
    done_nxt = 1'b0;
    beg_nxt = 1'b0;
    qc_nxt = (st_r == SCM_ENG_IDLE || tick) ? 16'h0000 : qc_r + 16'h0001;
    case (st_r)
      SCM_ENG_IDLE: begin
        // done_r blocks a restart while the finished command bit is still set
        if (!done_r && (cmd_stop || cmd_start || cmd_send || cmd_recv)) begin
          beg_nxt = 1'b1;
          ph_nxt = 2'h0;
          bit_nxt = 4'h0;
          nack_nxt = 1'b0;
          sh_nxt = tx_byte;
          if (cmd_stop) begin
            st_nxt = SCM_ENG_STOP;
            op_nxt = SCM_OP_STOP;
          end else if (cmd_start) begin
            st_nxt = SCM_ENG_START;
            op_nxt = SCM_OP_START;
          end else begin
            st_nxt = SCM_ENG_XFER;
            op_nxt = cmd_send ? SCM_OP_SEND : SCM_OP_RECV;
          end
        end
      end
      SCM_ENG_START: begin
        if (tick) begin
          ph_nxt = ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_rel_nxt = 1'b1;
            2'h1: scl_rel_nxt = 1'b1;
            2'h2: sda_rel_nxt = 1'b0;
            default: begin
              scl_rel_nxt = 1'b0;
              done_nxt = 1'b1;
              st_nxt = SCM_ENG_IDLE;
            end
          endcase
        end
      end
      SCM_ENG_STOP: begin
        if (tick) begin
          ph_nxt = ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_rel_nxt = 1'b0;
            2'h1: scl_rel_nxt = 1'b1;
            2'h2: sda_rel_nxt = 1'b1;
            default: begin
              done_nxt = 1'b1;
              st_nxt = SCM_ENG_IDLE;
            end
          endcase
        end
      end
      SCM_ENG_XFER: begin
        if (tick) begin
          ph_nxt = ph_r + 2'h1;
          case (ph_r)
            2'h0: begin
              if (bit_r != 4'h8) begin
                sda_rel_nxt = (op_r == SCM_OP_SEND) ? sh_r[7] : 1'b1;
              end else begin
                sda_rel_nxt = (op_r == SCM_OP_SEND) ? 1'b1 : !ack_select;
              end
            end
            2'h1: scl_rel_nxt = 1'b1;
            2'h2: begin
              // a slave holding scl low stretches the high phase
              if (!scl_in) begin
                ph_nxt = ph_r;
              end else if (bit_r != 4'h8) begin
                sh_nxt = {sh_r[6:0], sda_in};
              end else begin
                nack_nxt = (op_r == SCM_OP_SEND) && sda_in;
              end
            end
            default: begin
              scl_rel_nxt = 1'b0;
              if (bit_r == 4'h8) begin
                done_nxt = 1'b1;
                st_nxt = SCM_ENG_IDLE;
                if (op_r == SCM_OP_RECV) begin
                  rx_nxt = sh_r;
                end
              end else begin
                bit_nxt = bit_r + 4'h1;
              end
            end
          endcase
        end
      end
      default: st_nxt = SCM_ENG_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= SCM_ENG_IDLE;
      op_r <= SCM_OP_RECV;
      qc_r <= 16'h0000;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rx_r <= 8'h00;
      scl_rel_r <= 1'b1;
      sda_rel_r <= 1'b1;
      done_r <= 1'b0;
      beg_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      qc_r <= qc_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      scl_rel_r <= scl_rel_nxt;
      sda_rel_r <= sda_rel_nxt;
      done_r <= done_nxt;
      beg_r <= beg_nxt;
      nack_r <= nack_nxt;
    end
  end
  chk_ack_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == SCM_ENG_XFER && op_r == SCM_OP_RECV && bit_r == 4'h8 && ph_r == 2'h0 && tick)
    |=> (sda_oe == $past(ack_select)))
    else $error("ack level after received byte does not follow ack select");
endmodule : scm_i2c_engine
`default_nettype wire

//--- scm_slave_model.sv
// i2c slave partner model: acks sent bytes, returns a byte on reads
`default_nettype none
module scm_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic rd,
  input wire logic ack_en,
  input wire logic [7:0] rd_byte,
  output logic sda_oe,
  output logic [7:0] got,
  output logic master_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 9;
  // a start arms the count; a stop parks it so nothing is driven
  always @(negedge sda) if (scl) cnt = -1;
  always @(posedge sda) if (scl) cnt = 9;
  always @(posedge scl) begin
    if (cnt < 8) got = {got[6:0], sda};
    if (cnt == 8) master_ack = !sda;
  end
  always @(negedge scl) cnt = (cnt >= 8) ? 0 : cnt + 1;
  // open drain: a released line floats high through the pull-up
  assign sda_oe = rd ? (cnt inside {[0:7]} && !rd_byte[7-cnt]) : (cnt == 8 && ack_en);
endmodule : scm_slave_model
`default_nettype wire

//--- serial_ctrl_i2c_master_spi_status_test.sv
// self-checking bench for the serial controller
`default_nettype none
`include "scm_regs.svh"
module serial_ctrl_i2c_master_spi_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] SPI = `SCM_IDX_SPI_STAT * 32'h4;
  localparam logic [31:0] IST = `SCM_IDX_I2C_STAT * 32'h4;
  localparam logic [31:0] CMD = `SCM_IDX_I2C_CMD * 32'h4;
  localparam logic [31:0] ACK = `SCM_IDX_I2C_ACK * 32'h4;
  localparam logic [31:0] DAT = `SCM_IDX_DATA * 32'h4;
  localparam logic [31:0] INS = `SCM_IDX_INT_STAT * 32'h4;
  localparam logic [31:0] INM = `SCM_IDX_INT_MASK * 32'h4;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, mode_i2c = 1, spi_rx_valid = 0;
  logic spi_tx_ready = 0, spi_tx_busy = 0, rd = 0, ack_en = 1;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rdat, hrdata;
  logic [7:0] spi_rx_data = 0, rd_byte = 0, got, spi_tx_data;
  logic hreadyout, hresp, irq, scl_out, scl_oe, sda_out, sda_oe, s_oe, m_ack;
  logic spi_rx_ready, spi_tx_valid;
  int mismatches = 0, comparisons = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || s_oe);
  scm_serial_ctrl #(.QTR_CYCLES(2)) scm_serial_ctrl_inst (.clk, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .irq, .mode_i2c, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out,
    .sda_oe, .spi_rx_data, .spi_rx_valid, .spi_rx_ready, .spi_tx_data, .spi_tx_valid,
    .spi_tx_ready, .spi_tx_busy);
  scm_slave_model scm_slave_model_inst (.scl, .sda, .rd, .ack_en, .rd_byte,
    .sda_oe(s_oe), .got, .master_ack(m_ack));
  initial forever #12.5 clk = ~clk;
  task automatic final_report;
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : bus
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(rdat, e);
  endtask : rchk
  // issue a command, poll until it self-clears, then check the status flags
  task automatic cmd(input logic [31:0] c, input logic [31:0] e);
    int n;
    n = 0;
    bus(1, CMD, c);
    do begin
      bus(0, CMD, 0);
      n++;
    end while (rdat !== 32'h0 && n < 200);
    chk(rdat, 32'h0);
    rchk(IST, e);
  endtask : cmd
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk({hreadyout, hresp, scl_out, sda_out, scl_oe, sda_oe, spi_tx_valid, irq}, 8'h80);
    rchk(IST, 32'h0);
    rchk(CMD, 32'h0);
    rchk(ACK, 32'h0);
    rchk(SPI, 32'hc);
    rchk(32'h0, 32'h0);
    bus(1, INM, 32'h1f);
    cmd(32'h4, 32'h8);
    chk(irq, 1'b1);
    rchk(INS, 32'h8);
    bus(1, INS, 32'h8);
    @(posedge clk);
    chk(irq, 1'b0);
    bus(1, DAT, 32'ha5);
    cmd(32'h2, 32'h2);
    chk(got, 8'ha5);
    ack_en <= 0;
    bus(1, DAT, 32'h5a);
    cmd(32'h2, 32'h3);
    chk(got, 8'h5a);
    rd <= 1;
    rd_byte <= 8'h3c;
    bus(1, ACK, 32'h1);
    cmd(32'h1, 32'h4);
    chk(m_ack, 1'b1);
    rchk(DAT, 32'h3c);
    rd_byte <= 8'hc3;
    bus(1, ACK, 32'h0);
    cmd(32'h1, 32'h4);
    chk(m_ack, 1'b0);
    rchk(DAT, 32'hc3);
    rd <= 0;
    cmd(32'h8, 32'h8);
    rchk(INS, 32'hf);
    bus(1, INS, 32'hf);
    mode_i2c <= 0;
    spi_rx_valid <= 1;
    repeat (5) begin
      spi_rx_data <= spi_rx_data + 8'h1;
      @(posedge clk);
    end
    spi_rx_valid <= 0;
    chk(spi_rx_ready, 1'b0);
    rchk(SPI, 32'hf);
    rchk(INS, 32'h10);
    rchk(DAT, 32'h1);
    rchk(SPI, 32'he);
    repeat (3) bus(0, DAT, 0);
    rchk(SPI, 32'hc);
    chk(spi_rx_ready, 1'b1);
    repeat (4) bus(1, DAT, 32'h77);
    @(posedge clk);
    rchk(SPI, 32'h0);
    chk(spi_tx_data, 8'h77);
    spi_tx_ready <= 1;
    spi_tx_busy <= 1;
    repeat (6) @(posedge clk);
    spi_tx_ready <= 0;
    rchk(SPI, 32'h4);
    spi_tx_busy <= 0;
    @(posedge clk);
    rchk(SPI, 32'hc);
    final_report;
  end
  initial begin
    #750000;
    mismatches++;
    final_report;
  end
endmodule : serial_ctrl_i2c_master_spi_status_test
`default_nettype wire
